// ==== hw/pssi_defs.svh ====
// Constants of the potentiometer serial slave interface
`ifndef PSSI_DEFS_SVH
`define PSSI_DEFS_SVH
// System clock rate in Hz
`define PSSI_CLK_HZ 20000000
// Longest non-volatile programming time in milliseconds
`define PSSI_PROG_TIME_MS 5
// Programming time in clock cycles, a longest time rounded down
`define PSSI_PROG_CYCLES ((`PSSI_PROG_TIME_MS * `PSSI_CLK_HZ) / 1000)
// Device-type code default; value is arbitrary
`define PSSI_DEV_TYPE_DEF 4'ha
// Index of the last bit of a byte
`define PSSI_LAST_BIT 3'h7
// Byte index of the instruction byte, and the saturating top index
`define PSSI_IDX_INSTR 2'h0
`define PSSI_IDX_TOP 2'h3
`endif

// ==== hw/pssi_pkg.sv ====
// Types of the potentiometer serial slave interface
package pssi_pkg;
  typedef enum logic [2:0] {
    PSSI_ST_IDLE = 3'h0,
    PSSI_ST_ADDR = 3'h1,
    PSSI_ST_ADDR_ACK = 3'h2,
    PSSI_ST_RX = 3'h3,
    PSSI_ST_RX_ACK = 3'h4,
    PSSI_ST_TX = 3'h5,
    PSSI_ST_TX_ACK = 3'h6,
    PSSI_ST_TX_LOAD = 3'h7
  } pssi_state_t;
endpackage : pssi_pkg

// ==== hw/pssi_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs
module pssi_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("pssi_sync needs WIDTH of at least one");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;
      logic out_next;
      // A change counts only once stages two and three agree
      always_comb
      begin
        out_next = out_reg;
        if (s2_reg == s3_reg)
        begin
          out_next = s3_reg;
        end
      end
      // Idle level of open-drain lines is high
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          s3_reg <= 1'b1;
          out_reg <= 1'b1;
        end
        else
        begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          out_reg <= out_next;
        end
      end
      assign dout[i] = out_reg;
    end
  endgenerate
endmodule : pssi_sync

// ==== hw/pssi_prog_timer.sv ====
// Non-volatile programming cycle timer
module pssi_prog_timer #(
  parameter int unsigned CYCLES = 100000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic busy
);
  localparam int unsigned W = (CYCLES < 2) ? 1 : $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  generate
    if (CYCLES < 2)
    begin : g_chk
      $error("pssi_prog_timer needs CYCLES of at least two");
    end
  endgenerate

  logic busy_reg;
  logic busy_next;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Busy lasts exactly CYCLES clocks from the start pulse
  always_comb
  begin
    busy_next = busy_reg;
    cnt_next = cnt_reg;
    if (!busy_reg && start)
    begin
      busy_next = 1'b1;
      cnt_next = '0;
    end
    else if (busy_reg)
    begin
      cnt_next = cnt_reg + 1'b1;
      if (cnt_reg == LAST)
      begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else
    begin
      busy_reg <= busy_next;
      cnt_reg <= cnt_next;
    end
  end

  assign busy = busy_reg;

  busy_bound_a: assert property (@(posedge clk) disable iff (reset)
    (busy_reg && cnt_reg == LAST) |=> !busy_reg)
    else $error("programming ran past its longest time");
  start_busy_a: assert property (@(posedge clk) disable iff (reset)
    (start && !busy_reg) |=> busy_reg && (cnt_reg == '0))
    else $error("programming did not start");
endmodule : pssi_prog_timer

// ==== hw/pssi_top.sv ====
// Serial slave bus interface of a dual digital potentiometer
`include "pssi_defs.svh"
module pssi_top
  import pssi_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PSSI_PROG_CYCLES,
  parameter logic [3:0] DEV_TYPE = `PSSI_DEV_TYPE_DEF // value is arbitrary
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit3,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic [1:0] rx_index,
  input wire logic rd_sel,
  input wire logic [7:0] tx_byte,
  output logic tx_req,
  input wire logic nv_write_sel,
  output logic prog_start,
  output logic prog_busy,
  output logic wiper_load_from_nv
);
  logic scl_f;
  logic sda_f;
  logic [3:0] strap_f;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_match;

  // Bus lines and straps all come from outside the clock domain
  pssi_sync #(
    .WIDTH(6)
  ) pssi_sync_inst (
    .clk(clk),
    .reset(reset),
    .din({addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
      sda_in, scl_in}),
    .dout({strap_f, sda_f, scl_f})
  );

  // Delayed copies for edge finding
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  // Bus events; data moving with clock high is never a data bit
  assign scl_rise = scl_f && !scl_d_reg;
  assign scl_fall = !scl_f && scl_d_reg;
  assign start_ev = scl_f && scl_d_reg && sda_d_reg && !sda_f;
  assign stop_ev = scl_f && scl_d_reg && !sda_d_reg && sda_f;

  pssi_state_t state_reg;
  pssi_state_t state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic full_reg;
  logic full_next;
  logic oe_reg;
  logic oe_next;
  logic [1:0] idx_reg;
  logic [1:0] idx_next;
  logic rdm_reg;
  logic rdm_next;
  logic wrote_reg;
  logic wrote_next;
  logic rxv_reg;
  logic rxv_next;
  logic [7:0] rxb_reg;
  logic [7:0] rxb_next;
  logic [1:0] rxi_reg;
  logic [1:0] rxi_next;
  logic txr_reg;
  logic txr_next;
  logic pstart_reg;
  logic pstart_next;

  // Upper nibble is the type code, lower nibble the strap levels
  assign addr_match = (shift_reg[7:4] == DEV_TYPE) && (shift_reg[3:0] == strap_f);

  // Bus sequencer; STOP and START take priority over any state
  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    full_next = full_reg;
    oe_next = oe_reg;
    idx_next = idx_reg;
    rdm_next = rdm_reg;
    wrote_next = wrote_reg;
    rxv_next = 1'b0;
    rxb_next = rxb_reg;
    rxi_next = rxi_reg;
    txr_next = 1'b0;
    pstart_next = 1'b0;
    if (stop_ev)
    begin
      state_next = PSSI_ST_IDLE;
      oe_next = 1'b0;
      full_next = 1'b0;
      wrote_next = 1'b0; // A later stray STOP must not program again
      // Only a write that carried a data byte programs the array
      if (wrote_reg && !rdm_reg && nv_write_sel && !prog_busy)
      begin
        pstart_next = 1'b1;
      end
    end
    else if (start_ev)
    begin
      state_next = PSSI_ST_ADDR;
      bit_cnt_next = 3'h0;
      full_next = 1'b0;
      oe_next = 1'b0;
      idx_next = `PSSI_IDX_INSTR;
      rdm_next = 1'b0;
      wrote_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        PSSI_ST_IDLE:
        begin
          oe_next = 1'b0;
        end
        PSSI_ST_ADDR, PSSI_ST_RX:
        begin
          if (scl_rise && !full_reg)
          begin
            shift_next = {shift_reg[6:0], sda_f};
            bit_cnt_next = bit_cnt_reg + 3'h1;
            full_next = (bit_cnt_reg == `PSSI_LAST_BIT);
            if (state_reg == PSSI_ST_RX && bit_cnt_reg == `PSSI_LAST_BIT)
            begin
              rxv_next = 1'b1;
              rxb_next = {shift_reg[6:0], sda_f};
              rxi_next = idx_reg;
            end
          end
          else if (scl_fall && full_reg)
          begin
            full_next = 1'b0;
            if (state_reg == PSSI_ST_RX)
            begin
              oe_next = 1'b1;
              state_next = PSSI_ST_RX_ACK;
            end
            else if (addr_match && !prog_busy)
            begin
              oe_next = 1'b1;
              state_next = PSSI_ST_ADDR_ACK;
            end
            else
            begin
              // Busy or not ours: stay released until the next START
              state_next = PSSI_ST_IDLE;
            end
          end
        end
        PSSI_ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            oe_next = 1'b0;
            bit_cnt_next = 3'h0;
            state_next = PSSI_ST_RX;
          end
        end
        PSSI_ST_RX_ACK:
        begin
          // Decoder answers rd_sel by the rise of the ack clock, where it is read
          if (scl_rise && idx_reg == `PSSI_IDX_INSTR && rd_sel)
          begin
            rdm_next = 1'b1;
            txr_next = 1'b1;
          end
          if (scl_fall)
          begin
            bit_cnt_next = 3'h0;
            if (idx_reg != `PSSI_IDX_TOP)
            begin
              idx_next = idx_reg + 2'h1;
            end
            if (idx_reg != `PSSI_IDX_INSTR)
            begin
              wrote_next = 1'b1;
            end
            if (rdm_reg)
            begin
              shift_next = tx_byte;
              oe_next = !tx_byte[7];
              state_next = PSSI_ST_TX;
            end
            else
            begin
              oe_next = 1'b0;
              state_next = PSSI_ST_RX;
            end
          end
        end
        PSSI_ST_TX:
        begin
          // Data changes only while the clock is low
          if (scl_fall)
          begin
            if (bit_cnt_reg == `PSSI_LAST_BIT)
            begin
              oe_next = 1'b0;
              state_next = PSSI_ST_TX_ACK;
            end
            else
            begin
              bit_cnt_next = bit_cnt_reg + 3'h1;
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = !shift_reg[6];
            end
          end
        end
        PSSI_ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            if (!sda_f)
            begin
              txr_next = 1'b1;
              state_next = PSSI_ST_TX_LOAD;
            end
            else
            begin
              // No ack: hold off and idle until the next START
              state_next = PSSI_ST_IDLE;
            end
          end
        end
        PSSI_ST_TX_LOAD:
        begin
          if (scl_fall)
          begin
            shift_next = tx_byte;
            oe_next = !tx_byte[7];
            bit_cnt_next = 3'h0;
            state_next = PSSI_ST_TX;
          end
        end
        default:
        begin
          state_next = PSSI_ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= PSSI_ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      full_reg <= 1'b0;
      oe_reg <= 1'b0;
      idx_reg <= `PSSI_IDX_INSTR;
      rdm_reg <= 1'b0;
      wrote_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxb_reg <= 8'h00;
      rxi_reg <= 2'h0;
      txr_reg <= 1'b0;
      pstart_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      full_reg <= full_next;
      oe_reg <= oe_next;
      idx_reg <= idx_next;
      rdm_reg <= rdm_next;
      wrote_reg <= wrote_next;
      rxv_reg <= rxv_next;
      rxb_reg <= rxb_next;
      rxi_reg <= rxi_next;
      txr_reg <= txr_next;
      pstart_reg <= pstart_next;
    end
  end

  // Programming cycle; the timer keeps the bus disabled meanwhile
  pssi_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) pssi_prog_timer_inst (
    .clk(clk),
    .reset(reset),
    .start(pstart_reg),
    .busy(prog_busy)
  );

  logic wl_done_reg;
  logic wl_done_next;
  logic wl_pulse_reg;
  logic wl_pulse_next;

  // One load pulse after power-up reset releases
  always_comb
  begin
    wl_done_next = 1'b1;
    wl_pulse_next = !wl_done_reg;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wl_done_reg <= 1'b0;
      wl_pulse_reg <= 1'b0;
    end
    else
    begin
      wl_done_reg <= wl_done_next;
      wl_pulse_reg <= wl_pulse_next;
    end
  end

  // Open drain: only ever pull low; clock pin is input only
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;
  assign rx_byte = rxb_reg;
  assign rx_valid = rxv_reg;
  assign rx_index = rxi_reg;
  assign tx_req = txr_reg;
  assign prog_start = pstart_reg;
  assign wiper_load_from_nv = wl_pulse_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ack_on_match_a: assert property (
    (state_reg == PSSI_ST_ADDR && scl_fall && full_reg && addr_match && !prog_busy
      && !start_ev && !stop_ev) |=> oe_reg && state_reg == PSSI_ST_ADDR_ACK)
    else $error("own address not acknowledged");
  busy_no_ack_a: assert property (
    (state_reg == PSSI_ST_ADDR && prog_busy && scl_fall && full_reg) |=> !oe_reg)
    else $error("acknowledged while programming");
  mismatch_idle_a: assert property (
    (state_reg == PSSI_ST_ADDR && scl_fall && full_reg && !addr_match && !stop_ev
      && !start_ev) |=> !oe_reg && state_reg == PSSI_ST_IDLE)
    else $error("foreign address not ignored");
  byte_ack_a: assert property (
    (state_reg == PSSI_ST_RX && scl_fall && full_reg && !start_ev && !stop_ev)
      |=> oe_reg && state_reg == PSSI_ST_RX_ACK)
    else $error("received byte not acknowledged");
  ack_held_a: assert property (
    (state_reg == PSSI_ST_RX_ACK && oe_reg && !scl_fall && !start_ev && !stop_ev)
      |=> oe_reg)
    else $error("ack released inside ninth clock");
  start_addr_a: assert property (
    start_ev && !stop_ev |=> state_reg == PSSI_ST_ADDR && bit_cnt_reg == 3'h0 && !oe_reg)
    else $error("START not taken");
  stop_idle_a: assert property (
    stop_ev |=> state_reg == PSSI_ST_IDLE && !oe_reg)
    else $error("STOP not taken");
  nack_stop_a: assert property (
    (state_reg == PSSI_ST_TX_ACK && scl_rise && sda_f && !start_ev && !stop_ev)
      |=> state_reg == PSSI_ST_IDLE && !oe_reg && !txr_reg)
    else $error("transmit went on after no ack");
  prog_on_stop_a: assert property (
    (stop_ev && wrote_reg && !rdm_reg && nv_write_sel && !prog_busy)
      |=> pstart_reg ##1 prog_busy)
    else $error("programming not started after write");
  load_once_a: assert property (
    wl_pulse_reg |=> !wl_pulse_reg [*4])
    else $error("wiper load pulsed twice");
endmodule : pssi_top

// ==== tb/pssi_master_model.sv ====
// Behavioural bus master that makes the serial clock and data traffic
module pssi_master_model
(
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both lines released at power-up; the clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One bus clock of 8 cycles: low 5, high 3; data moves only while low
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    tick(2);
    sda <= b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    s = sda_wire; // Wire level just before the clock falls
  endtask : bit_io

  // Clock dips first so the same task serves a repeated START
  task automatic bus_start();
    tick(1);
    scl <= 1'b0;
    tick(2);
    sda <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda <= 1'b0;
    tick(4);
  endtask : bus_start

  // STOP, then bus free time before anyone may start again
  task automatic bus_stop();
    scl <= 1'b0;
    tick(2);
    sda <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda <= 1'b1;
    tick(8);
  endtask : bus_stop

  // Byte out MSB first, then release and sample the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // Byte in with lines released, then our acknowledge or not
  task automatic recv_byte(input logic ack_out, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(~ack_out, s);
  endtask : recv_byte
endmodule : pssi_master_model

// ==== tb/pssi_top_tb_top.sv ====
// Self-checking bench of the potentiometer serial slave interface
module pssi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PROG_N = 200;
  localparam logic [3:0] TYPE_CODE = 4'h6; // value is arbitrary
  localparam logic [7:0] TX_TAB [4] = '{8'hc3, 8'h5a, 8'h81, 8'h7e};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] strap = 4'h5;
  logic rd_sel = 1'b0;
  logic nv_write_sel = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic sda_out, sda_oe, rx_valid, tx_req, prog_start, prog_busy, wiper_load;
  logic [7:0] rx_byte;
  logic [1:0] rx_index;
  logic scl, msda;
  wire sda_wire = msda & ~(sda_oe & ~sda_out); // Open drain with pull-up
  int miscompares = 0;
  int tests_run = 0;
  int rx_cnt = 0, tx_cnt = 0, ps_cnt = 0, busy_cnt = 0, oe_busy = 0;

  always #25 clk = ~clk;

  pssi_master_model pssi_master_model_inst (.clk(clk), .sda_wire(sda_wire), .scl(scl),
    .sda(msda));

  pssi_top #(.PROG_CYCLES(PROG_N), .DEV_TYPE(TYPE_CODE)) pssi_top_inst (.clk(clk),
    .reset(reset), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .addr_strap_bit3(strap[3]), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_index(rx_index), .rd_sel(rd_sel), .tx_byte(tx_byte), .tx_req(tx_req),
    .nv_write_sel(nv_write_sel), .prog_start(prog_start), .prog_busy(prog_busy),
    .wiper_load_from_nv(wiper_load));

  // Event counters; the decoder stand-in answers each byte request
  always @(posedge clk)
  begin
    if (tx_req === 1'b1)
    begin
      tx_byte <= TX_TAB[tx_cnt % 4];
      tx_cnt <= tx_cnt + 1;
    end
    if (rx_valid === 1'b1)
      rx_cnt <= rx_cnt + 1;
    if (prog_start === 1'b1)
      ps_cnt <= ps_cnt + 1;
    if (prog_busy === 1'b1)
      busy_cnt <= busy_cnt + 1;
    if (prog_busy === 1'b1 && sda_oe === 1'b1)
      oe_busy <= oe_busy + 1;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic check_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_byte

  task automatic check_num(input int got, input int exp, input string what);
    tests_run++;
    if (got != exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : check_num

  // Full write: address, instruction, optional data byte, STOP
  task automatic write_txn(input logic [7:0] ins, input logic [7:0] dat, input logic with_dat);
    logic ack;
    int rb;
    rb = rx_cnt;
    pssi_master_model_inst.bus_start();
    pssi_master_model_inst.send_byte({TYPE_CODE, strap}, ack);
    check_bit(ack, 1'b1, "address ack");
    pssi_master_model_inst.send_byte(ins, ack);
    check_bit(ack, 1'b1, "instruction ack");
    check_byte(rx_byte, ins, "instruction byte");
    check_byte({6'h00, rx_index}, 8'h00, "instruction index");
    if (with_dat)
    begin
      pssi_master_model_inst.send_byte(dat, ack);
      check_bit(ack, 1'b1, "data ack");
      check_byte(rx_byte, dat, "data byte");
      check_byte({6'h00, rx_index}, 8'h01, "data index");
    end
    pssi_master_model_inst.bus_stop();
    check_num(rx_cnt - rb, with_dat ? 2 : 1, "bytes delivered");
  endtask : write_txn

  // Power-up pulse lands on the first edge after release, lines released
  task automatic test_powerup();
    @(posedge clk);
    #1;
    check_bit(wiper_load, 1'b1, "power-up load high");
    @(posedge clk);
    #1;
    check_bit(wiper_load, 1'b0, "power-up load one cycle");
    check_bit(sda_oe, 1'b0, "released after reset");
    check_bit(prog_busy, 1'b0, "idle after reset");
    repeat (20) @(posedge clk);
    $display("test_powerup done");
  endtask : test_powerup

  // Every strap value tried matches; any single flipped address bit is ignored
  task automatic test_address();
    logic ack;
    logic [7:0] good;
    int base;
    base = rx_cnt;
    for (int s = 0; s < 16; s += 5)
    begin
      strap <= s[3:0];
      good = {TYPE_CODE, s[3:0]};
      pssi_master_model_inst.bus_start();
      pssi_master_model_inst.send_byte(good, ack);
      check_bit(ack, 1'b1, "own address");
      pssi_master_model_inst.bus_stop();
      for (int i = 0; i < 8; i++)
      begin
        pssi_master_model_inst.bus_start();
        pssi_master_model_inst.send_byte(good ^ (8'h01 << i), ack);
        check_bit(ack, 1'b0, "foreign address");
        pssi_master_model_inst.send_byte(good, ack);
        check_bit(ack, 1'b0, "idle after mismatch");
        pssi_master_model_inst.bus_stop();
      end
    end
    check_num(rx_cnt, base, "bytes taken while unselected");
    $display("test_address done");
  endtask : test_address

  // An address without a START in front must not be answered
  task automatic test_no_start();
    logic ack;
    pssi_master_model_inst.send_byte({TYPE_CODE, strap}, ack);
    check_bit(ack, 1'b0, "address without start");
    pssi_master_model_inst.bus_stop();
    $display("test_no_start done");
  endtask : test_no_start

  // Volatile write, and a write with no data byte, start no programming
  task automatic test_write_volatile();
    logic ack;
    int base;
    base = ps_cnt;
    nv_write_sel <= 1'b0;
    write_txn(8'ha0, 8'h2a, 1'b1);
    // Long write: the byte index climbs and then stays at its top
    pssi_master_model_inst.bus_start();
    pssi_master_model_inst.send_byte({TYPE_CODE, strap}, ack);
    check_bit(ack, 1'b1, "long write address");
    for (int k = 0; k < 5; k++)
    begin
      pssi_master_model_inst.send_byte(8'h10 + k[7:0], ack);
      check_bit(ack, 1'b1, "long write ack");
      check_byte(rx_byte, 8'h10 + k[7:0], "long write byte");
      check_byte({6'h00, rx_index}, (k > 3) ? 8'h03 : k[7:0], "byte index");
    end
    pssi_master_model_inst.bus_stop();
    // A stray STOP after a finished write must not program
    nv_write_sel <= 1'b1;
    pssi_master_model_inst.bus_stop();
    write_txn(8'hc0, 8'h00, 1'b0);
    check_num(ps_cnt, base, "programming without cause");
    $display("test_write_volatile done");
  endtask : test_write_volatile

  // Non-volatile write, then polling until the device answers again
  task automatic test_write_nv();
    logic ack;
    int b0;
    int base;
    int n;
    b0 = busy_cnt;
    base = ps_cnt;
    nv_write_sel <= 1'b1;
    write_txn(8'hc1, 8'h3f, 1'b1);
    ack = 1'b0;
    for (n = 0; n < 8 && ack !== 1'b1; n++)
    begin
      pssi_master_model_inst.bus_start();
      pssi_master_model_inst.send_byte({TYPE_CODE, strap}, ack);
      if (n == 0)
        check_bit(ack, 1'b0, "poll while programming");
    end
    check_bit(ack, 1'b1, "poll after programming");
    pssi_master_model_inst.bus_stop();
    check_num(ps_cnt, base + 1, "programming started");
    check_num(busy_cnt - b0, PROG_N, "programming length");
    check_num(oe_busy, 0, "data driven while programming");
    $display("test_write_nv done");
  endtask : test_write_nv

  // Read two bytes, nack the second, then the device stays off the line
  task automatic test_read();
    logic ack;
    logic [7:0] d;
    int base;
    base = ps_cnt;
    rd_sel <= 1'b1;
    pssi_master_model_inst.bus_start();
    pssi_master_model_inst.send_byte({TYPE_CODE, strap}, ack);
    check_bit(ack, 1'b1, "read address ack");
    pssi_master_model_inst.send_byte(8'hb0, ack);
    check_bit(ack, 1'b1, "read instruction ack");
    pssi_master_model_inst.recv_byte(1'b1, d);
    check_byte(d, TX_TAB[0], "first read byte");
    pssi_master_model_inst.recv_byte(1'b0, d);
    check_byte(d, TX_TAB[1], "second read byte");
    pssi_master_model_inst.recv_byte(1'b1, d);
    check_byte(d, 8'hff, "silent after nack");
    check_num(tx_cnt, 2, "byte requests");
    pssi_master_model_inst.bus_stop();
    rd_sel <= 1'b0;
    check_num(ps_cnt, base, "programming after read");
    $display("test_read done");
  endtask : test_read

  // Watchdog: a hang counts as a mismatch and ends the run
  initial
  begin
    #4500000;
    miscompares++;
    $display("MISMATCH t=%0t run limit reached", $time);
    summarize();
  end

  // Reset for 12 cycles, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    test_powerup();
    test_address();
    test_no_start();
    test_write_volatile();
    test_write_nv();
    test_read();
    summarize();
  end
endmodule : pssi_top_tb_top
